//--- src/btag_map.vh
`ifndef BTAG_MAP_VH
`define BTAG_MAP_VH

// program-flow addressing modes
`define BTAG_MODE_W          4
`define BTAG_MODE_PC_REL     4'h0
`define BTAG_MODE_ABS_DIRECT 4'h1
`define BTAG_MODE_REL_DIRECT 4'h2
`define BTAG_MODE_ABS_INDEX  4'h3
`define BTAG_MODE_REL_INDEX  4'h4
`define BTAG_MODE_ABS_IND    4'h5
`define BTAG_MODE_REL_IND    4'h6
`define BTAG_MODE_ABS_OFFIND 4'h7
`define BTAG_MODE_REL_OFFIND 4'h8

// instruction classes presented with a request
`define BTAG_INSTR_W                  3
`define BTAG_INSTR_JUMP               3'h0
`define BTAG_INSTR_BRANCH             3'h1
`define BTAG_INSTR_CALL               3'h2
`define BTAG_INSTR_CALL_PC_RELATIVE   3'h3
`define BTAG_INSTR_JUMP_LONG_RELATIVE 3'h4

// register file layout
`define BTAG_RF_ADDR_W       8
`define BTAG_RF_INDEX_B      8'h01

`define BTAG_PC_W            16
`define BTAG_PC_RESET        16'h0000

`endif

//--- src/btag_target_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "btag_map.vh"

module btag_target_gen
(
    input  wire        i_ref_clk,
    input  wire        i_rst,
    input  wire        i_req,
    input  wire [3:0]  i_mode,
    input  wire [2:0]  i_instr,
    input  wire [15:0] i_operand16,
    input  wire [7:0]  i_offset8,
    input  wire [15:0] i_next_instr_addr,
    input  wire [7:0]  i_pointer_reg_low,
    input  wire [7:0]  i_rf_rdata_a,
    input  wire [7:0]  i_rf_rdata_b,
    input  wire [7:0]  i_rf_rdata_c,
    output wire [7:0]  o_rf_addr_a,
    output wire [7:0]  o_rf_addr_b,
    output wire [7:0]  o_rf_addr_c,
    output reg  [15:0] o_pc,
    output reg         o_pc_load,
    output reg         o_illegal
);

    // which operands a mode adds together
    reg         mode_known;
    reg         mode_relative;
    reg         pc_rel_mode;
    reg         use_op16;
    reg         use_index;
    reg         use_pair;
    reg         use_off8;

    // which instruction classes may use a mode
    reg         class_abs_ok;
    reg         class_rel_ok;
    reg         legal;

    // the three terms of the target sum
    reg  [15:0] term_a;
    reg  [15:0] term_b;
    reg  [15:0] base;
    reg  [16:0] sum_ab;
    reg  [16:0] sum_all;
    reg  [15:0] next_target;
    wire [15:0] off8_sx;
    wire [15:0] pair_val;
    wire [15:0] index_b;
    wire        take_load;
    wire        take_refuse;

    // three read ports: pointer low, pointer high, index b
    assign o_rf_addr_a = i_pointer_reg_low;
    // wraps from location 0 to the top of the file
    assign o_rf_addr_b = i_pointer_reg_low - 8'h01;
    assign o_rf_addr_c = `BTAG_RF_INDEX_B;

    assign pair_val = {i_rf_rdata_b, i_rf_rdata_a};
    assign index_b  = {8'h00, i_rf_rdata_c};
    // two's-complement byte reach gives -128..+127
    assign off8_sx  = {{8{i_offset8[7]}}, i_offset8};

    always @*
    begin
        mode_known    = 1'b1;
        mode_relative = 1'b0;
        pc_rel_mode   = 1'b0;
        use_op16      = 1'b0;
        use_index     = 1'b0;
        use_pair      = 1'b0;
        use_off8      = 1'b0;
        case (i_mode)
            `BTAG_MODE_PC_REL:
            begin
                mode_relative = 1'b1;
                pc_rel_mode   = 1'b1;
                use_off8      = 1'b1;
            end
            `BTAG_MODE_ABS_DIRECT:
            begin
                use_op16 = 1'b1;
            end
            `BTAG_MODE_REL_DIRECT:
            begin
                mode_relative = 1'b1;
                use_op16      = 1'b1;
            end
            `BTAG_MODE_ABS_INDEX:
            begin
                use_op16  = 1'b1;
                use_index = 1'b1;
            end
            `BTAG_MODE_REL_INDEX:
            begin
                mode_relative = 1'b1;
                use_op16      = 1'b1;
                use_index     = 1'b1;
            end
            `BTAG_MODE_ABS_IND:
            begin
                use_pair = 1'b1;
            end
            `BTAG_MODE_REL_IND:
            begin
                mode_relative = 1'b1;
                use_pair      = 1'b1;
            end
            `BTAG_MODE_ABS_OFFIND:
            begin
                use_pair = 1'b1;
                use_off8 = 1'b1;
            end
            `BTAG_MODE_REL_OFFIND:
            begin
                mode_relative = 1'b1;
                use_pair      = 1'b1;
                use_off8      = 1'b1;
            end
            default:
            begin
                mode_known = 1'b0;
            end
        endcase
    end

    // absolute modes belong only to branch and call
    always @*
    begin
        class_abs_ok = 1'b0;
        case (i_instr)
            `BTAG_INSTR_BRANCH:
            begin
                class_abs_ok = 1'b1;
            end
            `BTAG_INSTR_CALL:
            begin
                class_abs_ok = 1'b1;
            end
            default:
            begin
                class_abs_ok = 1'b0;
            end
        endcase
    end

    // long relative modes belong only to relative call and long jump
    always @*
    begin
        class_rel_ok = 1'b0;
        case (i_instr)
            `BTAG_INSTR_CALL_PC_RELATIVE:
            begin
                class_rel_ok = 1'b1;
            end
            `BTAG_INSTR_JUMP_LONG_RELATIVE:
            begin
                class_rel_ok = 1'b1;
            end
            default:
            begin
                class_rel_ok = 1'b0;
            end
        endcase
    end

    always @*
    begin
        if (!mode_known)
        begin
            legal = 1'b0;
        end
        else if (!mode_relative)
        begin
            legal = class_abs_ok;
        end
        else if (pc_rel_mode)
        begin
            // short jumps are shared by many classes, never refused
            legal = 1'b1;
        end
        else
        begin
            legal = class_rel_ok;
        end
    end

    // first term: the 16-bit constant or the pointer pair
    always @*
    begin
        if (use_pair)
        begin
            term_a = pair_val;
        end
        else if (use_op16)
        begin
            term_a = i_operand16;
        end
        else
        begin
            term_a = 16'h0000;
        end
    end

    // second term: index b or the signed byte offset
    always @*
    begin
        if (use_index)
        begin
            term_b = index_b;
        end
        else if (use_off8)
        begin
            term_b = off8_sx;
        end
        else
        begin
            term_b = 16'h0000;
        end
    end

    // relative modes start from the following instruction
    always @*
    begin
        if (mode_relative)
        begin
            base = i_next_instr_addr;
        end
        else
        begin
            base = 16'h0000;
        end
    end

    // carries out of bit 15 are dropped on purpose, so a signed
    // 16-bit offset and an unsigned one give the same target
    always @*
    begin
        sum_ab      = {1'b0, term_a} + {1'b0, term_b};
        sum_all     = {1'b0, sum_ab[15:0]} + {1'b0, base};
        next_target = sum_all[15:0];
    end

    assign take_load   = i_req && legal;
    assign take_refuse = i_req && !legal;

    // a refused request leaves pc untouched and flags it
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pc <= `BTAG_PC_RESET;
        end
        else if (take_load)
        begin
            o_pc <= next_target;
        end
    end

    // one-cycle pulse per loaded request
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pc_load <= 1'b0;
        end
        else
        begin
            o_pc_load <= take_load;
        end
    end

    // one-cycle pulse per refused request
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_illegal <= 1'b0;
        end
        else
        begin
            o_illegal <= take_refuse;
        end
    end

endmodule
`default_nettype wire

//--- verification/btag_rf_model.sv
`timescale 1ns/1ps
`default_nettype none
module btag_rf_model (
    input  wire logic [7:0] i_addr_a, i_addr_b, i_addr_c,
    output logic [7:0]      o_data_a, o_data_b, o_data_c
);
    // inverted address as contents, so both bytes of a pair differ
    assign o_data_a = ~i_addr_a;
    assign o_data_b = ~i_addr_b;
    assign o_data_c = ~i_addr_c;
endmodule
`default_nettype wire

//--- verification/btag_target_gen_properties.sv
`timescale 1ns/1ps
`default_nettype none
module btag_target_gen_props (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_req,
    input wire logic [3:0]  i_mode,
    input wire logic [2:0]  i_instr,
    input wire logic [15:0] i_operand16,
    input wire logic [7:0]  i_offset8,
    input wire logic [15:0] i_next_instr_addr,
    input wire logic [7:0]  i_pointer_reg_low,
    input wire logic [7:0]  i_rf_rdata_a,
    input wire logic [7:0]  i_rf_rdata_b,
    input wire logic [7:0]  i_rf_rdata_c,
    input wire logic [7:0]  o_rf_addr_a,
    input wire logic [7:0]  o_rf_addr_b,
    input wire logic [7:0]  o_rf_addr_c,
    input wire logic [15:0] o_pc,
    input wire logic        o_pc_load,
    input wire logic        o_illegal
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire        branch_ok = i_instr == 3'h1 || i_instr == 3'h2;
    wire        long_ok = i_instr == 3'h3 || i_instr == 3'h4;
    wire [15:0] off8_sx = {{8{i_offset8[7]}}, i_offset8};
    wire [15:0] pair = {i_rf_rdata_b, i_rf_rdata_a};
    wire [15:0] rel8 = i_next_instr_addr + off8_sx;
    wire [15:0] rel16 = i_next_instr_addr + i_operand16;
    wire [15:0] abs_index = i_operand16 + {8'h00, i_rf_rdata_c};
    wire [15:0] rel_offind = i_next_instr_addr + pair + off8_sx;
    chk_bad_mode: assert property (i_req && i_mode > 4'h8 |=> o_illegal)
        else $error("mode not refused");
    chk_one_answer: assert property (i_req |=> o_pc_load != o_illegal)
        else $error("no single answer");
    chk_abs_class: assert property (i_req && i_mode == 4'h1
        && !branch_ok |=> o_illegal && !o_pc_load)
        else $error("abs misuse taken");
    chk_abs_direct: assert property (i_req && i_mode == 4'h1
        && branch_ok |=> o_pc_load && o_pc == $past(i_operand16))
        else $error("abs direct");
    chk_pc_rel: assert property (i_req && i_mode == 4'h0
        |=> o_pc_load && o_pc == $past(rel8)) else $error("pc relative");
    chk_rel_direct: assert property (i_req && i_mode == 4'h2
        && long_ok |=> o_pc == $past(rel16)) else $error("rel direct");
    chk_abs_index: assert property (i_req && i_mode == 4'h3
        && branch_ok |=> o_pc_load && o_pc == $past(abs_index))
        else $error("abs indexed");
    chk_rel_offind: assert property (i_req && i_mode == 4'h8
        && long_ok |=> o_pc_load && o_pc == $past(rel_offind))
        else $error("rel offset indirect");
    chk_pair_low: assert property (o_rf_addr_a == i_pointer_reg_low)
        else $error("pointer low address");
    chk_pair_addr: assert property (o_rf_addr_b == o_rf_addr_a - 8'h01)
        else $error("pair address");
    chk_index_loc: assert property (o_rf_addr_c == 8'h01)
        else $error("index location");
    chk_idle_quiet: assert property (!i_req |=> !o_pc_load && !o_illegal)
        else $error("spurious pulse");
    chk_hold_pc: assert property (o_illegal |-> $stable(o_pc))
        else $error("pc moved on refusal");
    cov_load: cover property (o_pc_load ##1 o_pc_load);
    cov_refuse: cover property (o_illegal);
    cov_offind: cover property (i_req && i_mode == 4'h8 ##1 o_pc_load);
endmodule
bind btag_target_gen btag_target_gen_props u_props (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_req(i_req),
    .i_mode(i_mode),
    .i_instr(i_instr),
    .i_operand16(i_operand16),
    .i_offset8(i_offset8),
    .i_next_instr_addr(i_next_instr_addr),
    .i_pointer_reg_low(i_pointer_reg_low),
    .i_rf_rdata_a(i_rf_rdata_a),
    .i_rf_rdata_b(i_rf_rdata_b),
    .i_rf_rdata_c(i_rf_rdata_c),
    .o_rf_addr_a(o_rf_addr_a),
    .o_rf_addr_b(o_rf_addr_b),
    .o_rf_addr_c(o_rf_addr_c),
    .o_pc(o_pc),
    .o_pc_load(o_pc_load),
    .o_illegal(o_illegal)
);
`default_nettype wire

//--- verification/btag_target_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module btag_target_gen_tb_top;
    logic        clk = 0, rst = 1, req = 0;
    logic [3:0]  mode = 4'h0;
    logic [2:0]  instr = 3'h0;
    logic [15:0] op = 16'h0000, nxt = 16'h1000;
    logic [7:0]  off = 8'h00, ptr_low = 8'h05;
    wire  [15:0] pc;
    wire  [7:0]  ra, rb, rc, da, db, dc;
    wire         pcl, ill;
    int          fail_count = 0, checks = 0;
    // mode, class, operand, offset, pointer, next, expected pc, refused
    logic [79:0] rows [14] = '{80'h00_0000_80_05_1000_0f80_00,
        80'h01_0000_7f_05_2000_207f_00, 80'h11_5432_00_05_1000_5432_00,
        80'h24_f000_00_05_1000_0000_00, 80'h32_1234_00_05_3000_1332_00,
        80'h43_fff0_00_05_1000_10ee_00, 80'h51_0000_00_05_4000_fbfa_00,
        80'h64_0000_00_00_1000_10ff_00, 80'h72_0000_7f_05_1000_fc79_00,
        80'h83_0000_fe_05_1000_0bf8_00, 80'h14_1111_00_05_1000_0bf8_01,
        80'h21_2222_00_05_1000_0bf8_01, 80'h93_0000_00_05_1000_0bf8_01,
        80'h50_0000_00_05_1000_0bf8_01};
    initial forever #2 clk = ~clk;
    btag_target_gen dut (.i_ref_clk(clk), .i_rst(rst), .i_req(req),
        .i_mode(mode), .i_instr(instr), .i_operand16(op), .i_offset8(off),
        .i_next_instr_addr(nxt), .i_pointer_reg_low(ptr_low),
        .i_rf_rdata_a(da), .i_rf_rdata_b(db), .i_rf_rdata_c(dc),
        .o_rf_addr_a(ra), .o_rf_addr_b(rb), .o_rf_addr_c(rc),
        .o_pc(pc), .o_pc_load(pcl), .o_illegal(ill));
    btag_rf_model rf (.i_addr_a(ra), .i_addr_b(rb), .i_addr_c(rc),
        .o_data_a(da), .o_data_b(db), .o_data_c(dc));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("fail_count=%0d checks=%0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #2000;
        fail_count++;
        stop_test;
    end
    initial
    begin
        repeat (12) @(posedge clk);
        chk(pc, 16'h0000);
        rst <= 0;
        // rows go back to back; each result is seen one edge later
        for (int i = 0; i <= 14; i++)
        begin
            @(posedge clk);
            req <= i < 14;
            if (i < 14)
                {mode, instr, op, off, ptr_low, nxt} <=
                    {rows[i][79:76], rows[i][74:24]};
            #1;
            if (i > 0)
            begin
                chk(pc, rows[i-1][23:8]);
                chk({pcl, ill}, {~rows[i-1][0], rows[i-1][0]});
            end
        end
        @(posedge clk);
        rst <= 1;
        #1 chk({pcl, ill}, 16'h0000);
        chk(pc, 16'h0000);
        @(posedge clk);
        {rst, req, mode, off} <= {2'b01, 4'h0, 8'h80};
        @(posedge clk);
        req <= 0;
        #1 chk(pc, 16'h0f80);
        chk({pcl, ill}, 16'h0002);
        stop_test;
    end
endmodule
`default_nettype wire
